// [logic/srlm_pkg.sv]
package srlm_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int LOCK_W = 7;
	localparam int CNT_W  = 6;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_IRQ_EN        = 7'h04;
	localparam logic [ADDR_W-1:0] ADDR_SCRATCH_FIRST = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_LOCK          = 7'h0A;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_FIRST    = 7'h0B;
	localparam logic [ADDR_W-1:0] ADDR_RSVD_LAST     = 7'h0F;
	localparam logic [ADDR_W-1:0] ADDR_FAIL_STATUS   = 7'h61;
	localparam logic [ADDR_W-1:0] ADDR_STEP          = 7'h01;

	// lock areas, index = lock bit position
	localparam logic [LOCK_W-1:0][ADDR_W-1:0] AREA_FIRST = {7'h68, 7'h50, 7'h40, 7'h30, 7'h20, 7'h10, 7'h06};
	localparam logic [LOCK_W-1:0][ADDR_W-1:0] AREA_LAST  = {7'h6F, 7'h5F, 7'h4F, 7'h3F, 7'h2F, 7'h1F, 7'h09};
	localparam int LK_SCRATCH  = 0;
	localparam int LK_IO_BANK0 = 3;
	localparam int LK_IO_BANK1 = 4;
	localparam int LK_DATAMASK = 6;

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int BIT_FAIL_IRQ_EN = 1;
	localparam int BIT_FAIL_FLAG   = 1;
	localparam logic [DATA_W-1:0] BYTE_ZERO    = 8'h00;
	localparam logic [31:0]       SCRATCH_ZERO = 32'h0000_0000;
	localparam logic [LOCK_W-1:0] LOCK_ZERO    = 7'h00;

	// ----------------------------------------
	// frame lengths in bits
	// ----------------------------------------
	localparam logic [CNT_W-1:0] LEN_ADDR = 6'h08;
	localparam logic [CNT_W-1:0] LEN_ONE  = 6'h10;
	localparam logic [CNT_W-1:0] LEN_TWO  = 6'h18;
	localparam logic [CNT_W-1:0] LEN_THREE = 6'h20;
	localparam logic [CNT_W-1:0] CNT_MAX  = 6'h3F;
	localparam logic [CNT_W-1:0] CNT_STEP = 6'h01;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_FORCED_NORMAL,
		MODE_STANDBY,
		MODE_NORMAL,
		MODE_SLEEP,
		MODE_RESET,
		MODE_OVERLOAD,
		MODE_FAILSAFE
	} srlm_mode_t;

	typedef enum logic {
		CM_IDLE,
		CM_WRITE
	} srlm_commit_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} srlm_wr_t;

endpackage : srlm_pkg

// [logic/srlm_sync.sv]
module srlm_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// ----------------------------------------
	// two-stage synchroniser
	// ----------------------------------------
	logic [W-1:0] stage1;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1 <= INIT;
			dout   <= INIT;
		end
		else
		begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule : srlm_sync

// [logic/srlm_regmem.sv]
module srlm_regmem #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input  wire logic          clock,
	input  wire logic          rst_b,
	input  wire logic          wa_en,
	input  wire logic [AW-1:0] wa_addr,
	input  wire logic [DW-1:0] wa_data,
	input  wire logic          wb_en,
	input  wire logic [AW-1:0] wb_addr,
	input  wire logic [DW-1:0] wb_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);

	// ----------------------------------------
	// storage, port b after port a so hardware wins a tie
	// ----------------------------------------
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < 2**AW; i++)
				mem[i] <= '0;
			rd_data <= '0;
		end
		else
		begin
			if (wa_en)
				mem[wa_addr] <= wa_data;
			if (wb_en)
				mem[wb_addr] <= wb_data;
			rd_data <= mem[rd_addr];
		end
	end

endmodule : srlm_regmem

// [logic/srlm_lock_map.sv]
// Functional notes
// RULE1: lock bit 0 blocks writes to 0x06-0x09
// RULE2: lock bit 1 blocks writes to 0x10-0x1F
// RULE3: lock bit 2 blocks writes to 0x20-0x2F
// RULE4: lock bit 3 blocks 0x30-0x3F with bank0
// RULE5: lock bit 4 blocks 0x40-0x4F with bank1
// RULE6: lock bit 5 blocks writes to 0x50-0x5F
// RULE7: lock bit 6 blocks 0x68-0x6F, PN only
// RULE8: host writes bit 7 zero, ignores it
// RULE9: full access Standby/Normal, limited Forced Normal
// RULE10: Forced Normal hides flag, enable, locks
// RULE11: Off clears all; fail-safe clears flag, enable
// RULE12: flat 128-byte space, 0x00 to 0x7F
// RULE13: eight groups of sixteen addresses
// RULE14: absent registers unimplemented, read zero
// RULE15: lock register at 0x0A, bit 7 reserved
// RULE16: any locked target discards whole write, flags
// RULE17: write length not 16/24/32 aborts, flags
// RULE18: four bytes scratch memory at 0x06-0x09
// RULE19: all target addresses checked before commit
// RULE20: locks gate serial writes only, not hardware
module srlm_lock_map #(
	parameter bit HAS_IO_BANK0 = 1'b1,
	parameter bit HAS_IO_BANK1 = 1'b1,
	parameter bit HAS_PN       = 1'b1
) (
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic                  spi_sck,
	input  wire logic                  spi_cs_b,
	input  wire logic                  spi_sdi,
	output logic                       spi_sdo,
	output logic                       spi_sdo_oe_b,
	input  wire srlm_pkg::srlm_mode_t  op_mode,
	input  wire srlm_pkg::srlm_wr_t    hw_update,
	output srlm_pkg::srlm_wr_t         spi_commit,
	output logic [srlm_pkg::LOCK_W-1:0] area_lock_bits,
	output logic [31:0]                scratch_memory,
	output logic                       serial_failure_flag,
	output logic                       serial_failure_irq_enable,
	output logic                       serial_failure_irq
);

	// one bit per lock area: 6 data mask, 5 timer, 4 bank1, 3 bank0, 2:0 always present
	localparam logic [srlm_pkg::LOCK_W-1:0] LOCK_MASK = {HAS_PN, 1'h1, HAS_IO_BANK1, HAS_IO_BANK0, 3'h7};

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic in_area(input int idx, input logic [srlm_pkg::ADDR_W-1:0] a);
		in_area = (a >= srlm_pkg::AREA_FIRST[idx]) && (a <= srlm_pkg::AREA_LAST[idx]);
	endfunction : in_area

	function automatic logic area_locked(input logic [srlm_pkg::ADDR_W-1:0] a,
		input logic [srlm_pkg::LOCK_W-1:0] lk);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < srlm_pkg::LOCK_W; i++)
			hit = hit | (lk[i] & in_area(i, a)); // [RULE1] [RULE2] [RULE3] [RULE6]
		area_locked = hit;
	endfunction : area_locked

	// 7-bit address wraps, so the map is exactly 128 bytes
	function automatic logic addr_present(input logic [srlm_pkg::ADDR_W-1:0] a);
		logic ok;
		ok = !((a >= srlm_pkg::ADDR_RSVD_FIRST) && (a <= srlm_pkg::ADDR_RSVD_LAST)); // [RULE12] [RULE13]
		if (!HAS_IO_BANK0 && in_area(srlm_pkg::LK_IO_BANK0, a))
			ok = 1'b0; // [RULE14]
		if (!HAS_IO_BANK1 && in_area(srlm_pkg::LK_IO_BANK1, a))
			ok = 1'b0; // [RULE14]
		if (!HAS_PN && in_area(srlm_pkg::LK_DATAMASK, a))
			ok = 1'b0; // [RULE14]
		addr_present = ok;
	endfunction : addr_present

	function automatic logic spi_enabled(input srlm_pkg::srlm_mode_t m);
		spi_enabled = (m == srlm_pkg::MODE_STANDBY) || (m == srlm_pkg::MODE_NORMAL)
			|| (m == srlm_pkg::MODE_FORCED_NORMAL); // [RULE9]
	endfunction : spi_enabled

	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic sck_s;
	logic cs_b_s;
	logic sdi_s;
	logic sck_d;
	logic cs_b_d;

	srlm_sync #(
		.W    (3),
		.INIT (3'h2)
	) u_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   ({spi_sck, spi_cs_b, spi_sdi}),
		.dout  ({sck_s, cs_b_s, sdi_s})
	);

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sck_d  <= 1'b0;
			cs_b_d <= 1'b1;
		end
		else
		begin
			sck_d  <= sck_s;
			cs_b_d <= cs_b_s;
		end
	end

	logic sck_fall;
	logic sck_rise;
	logic frame_start;
	logic frame_end;
	logic fn_mode;
	logic clear_mode;

	assign sck_fall    = sck_d & ~sck_s;
	assign sck_rise    = ~sck_d & sck_s;
	assign frame_start = cs_b_d & ~cs_b_s;
	assign frame_end   = ~cs_b_d & cs_b_s;
	assign fn_mode     = (op_mode == srlm_pkg::MODE_FORCED_NORMAL);
	assign clear_mode  = (op_mode == srlm_pkg::MODE_OFF) || (op_mode == srlm_pkg::MODE_FAILSAFE);

	// ----------------------------------------
	// frame capture, sampled on falling sck
	// ----------------------------------------
	logic                                   frame_active;
	logic [srlm_pkg::CNT_W-1:0]             bit_count;
	logic [srlm_pkg::DATA_W-1:0]            shift_in;
	logic [srlm_pkg::ADDR_W-1:0]            cmd_addr;
	logic                                   cmd_ro;
	logic [2:0][srlm_pkg::DATA_W-1:0]       wdata;
	logic [srlm_pkg::CNT_W-1:0]             next_count;
	logic [srlm_pkg::DATA_W-1:0]            next_byte;
	logic                                   sample;

	assign sample     = frame_active & ~cs_b_s & sck_fall;
	assign next_count = (bit_count == srlm_pkg::CNT_MAX) ? bit_count : bit_count + srlm_pkg::CNT_STEP;
	assign next_byte  = {shift_in[srlm_pkg::DATA_W-2:0], sdi_s};

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frame_active <= 1'b0;
			bit_count    <= '0;
			shift_in     <= '0;
			cmd_addr     <= '0;
			cmd_ro       <= 1'b0;
			wdata        <= '0;
		end
		else if (frame_start)
		begin
			frame_active <= spi_enabled(op_mode); // [RULE9]
			bit_count    <= '0;
			cmd_ro       <= 1'b0;
		end
		else if (frame_end || !spi_enabled(op_mode))
			frame_active <= 1'b0; // [RULE9]
		else if (sample)
		begin
			shift_in  <= next_byte;
			bit_count <= next_count;
			unique case (next_count)
				srlm_pkg::LEN_ADDR:  {cmd_addr, cmd_ro} <= next_byte;
				srlm_pkg::LEN_ONE:   wdata[0] <= next_byte;
				srlm_pkg::LEN_TWO:   wdata[1] <= next_byte;
				srlm_pkg::LEN_THREE: wdata[2] <= next_byte;
				default:             ;
			endcase
		end
	end

	// ----------------------------------------
	// write check at chip-select release
	// ----------------------------------------
	logic       write_end;
	logic       len_ok;
	logic [1:0] nbytes;
	logic       lock_hit;
	logic       fail_event;
	logic       commit_start;

	assign write_end = frame_end & frame_active & ((bit_count < srlm_pkg::LEN_ADDR) | ~cmd_ro);
	assign len_ok    = (bit_count == srlm_pkg::LEN_ONE) || (bit_count == srlm_pkg::LEN_TWO)
		|| (bit_count == srlm_pkg::LEN_THREE); // [RULE17]
	assign nbytes    = 2'(bit_count[5:3] - 3'h1);
	// every target byte checked up front, nothing half-written
	assign lock_hit  = area_locked(cmd_addr, area_lock_bits)
		| ((nbytes >= 2'h2) & area_locked(cmd_addr + srlm_pkg::ADDR_STEP, area_lock_bits))
		| ((nbytes == 2'h3) & area_locked(7'(cmd_addr + 7'h02), area_lock_bits)); // [RULE19] [RULE16]
	assign fail_event   = write_end & (~len_ok | lock_hit); // [RULE16] [RULE17]
	assign commit_start = write_end & len_ok & ~lock_hit;

	// ----------------------------------------
	// commit sequencer, one byte per clock
	// ----------------------------------------
	srlm_pkg::srlm_commit_t      cm_state;
	logic [srlm_pkg::ADDR_W-1:0] cm_addr;
	logic [1:0]                  cm_idx;
	logic [1:0]                  cm_last;
	logic                        cw;
	logic [srlm_pkg::DATA_W-1:0] cw_data;

	assign cw      = (cm_state == srlm_pkg::CM_WRITE);
	assign cw_data = wdata[cm_idx];

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cm_state <= srlm_pkg::CM_IDLE;
			cm_addr  <= '0;
			cm_idx   <= '0;
			cm_last  <= '0;
		end
		else
		begin
			unique case (cm_state)
				srlm_pkg::CM_IDLE:
				begin
					if (commit_start)
					begin
						cm_state <= srlm_pkg::CM_WRITE;
						cm_addr  <= cmd_addr;
						cm_idx   <= '0;
						cm_last  <= nbytes - 2'h1;
					end
				end
				srlm_pkg::CM_WRITE:
				begin
					cm_addr <= cm_addr + srlm_pkg::ADDR_STEP; // overflow wraps to 0x00
					cm_idx  <= cm_idx + 2'h1;
					if (cm_idx == cm_last)
						cm_state <= srlm_pkg::CM_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// dedicated bits
	// ----------------------------------------
	logic is_lock;
	logic is_scratch;
	logic is_irq_en;
	logic is_fail;

	assign is_lock    = (cm_addr == srlm_pkg::ADDR_LOCK); // [RULE15]
	assign is_scratch = in_area(srlm_pkg::LK_SCRATCH, cm_addr);
	assign is_irq_en  = (cm_addr == srlm_pkg::ADDR_IRQ_EN);
	assign is_fail    = (cm_addr == srlm_pkg::ADDR_FAIL_STATUS);

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			area_lock_bits <= srlm_pkg::LOCK_ZERO;
		else if (op_mode == srlm_pkg::MODE_OFF)
			area_lock_bits <= srlm_pkg::LOCK_ZERO; // [RULE11]
		else if (cw && is_lock && !fn_mode)
			area_lock_bits <= cw_data[srlm_pkg::LOCK_W-1:0] & LOCK_MASK; // [RULE15] [RULE4] [RULE5] [RULE7] [RULE8]
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			scratch_memory <= srlm_pkg::SCRATCH_ZERO;
		else if (op_mode == srlm_pkg::MODE_OFF)
			scratch_memory <= srlm_pkg::SCRATCH_ZERO;
		else if (cw && is_scratch && !fn_mode)
			scratch_memory[{2'(cm_addr - srlm_pkg::ADDR_SCRATCH_FIRST), 3'h0} +: srlm_pkg::DATA_W] <= cw_data; // [RULE18]
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			serial_failure_irq_enable <= 1'b0;
		else if (clear_mode)
			serial_failure_irq_enable <= 1'b0; // [RULE11]
		else if (cw && is_irq_en && !fn_mode)
			serial_failure_irq_enable <= cw_data[srlm_pkg::BIT_FAIL_IRQ_EN];
	end

	// write-one-to-clear; a new failure in the same cycle wins
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			serial_failure_flag <= 1'b0;
		else if (clear_mode)
			serial_failure_flag <= 1'b0; // [RULE11]
		else
		begin
			if (cw && is_fail && !fn_mode && cw_data[srlm_pkg::BIT_FAIL_FLAG])
				serial_failure_flag <= 1'b0;
			if (fail_event)
				serial_failure_flag <= 1'b1; // [RULE16] [RULE17]
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serial_failure_irq <= 1'b0;
			spi_commit         <= '0;
		end
		else
		begin
			serial_failure_irq <= serial_failure_flag & serial_failure_irq_enable;
			spi_commit.valid   <= cw & addr_present(cm_addr);
			spi_commit.addr    <= cm_addr;
			spi_commit.data    <= cw_data;
		end
	end

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic                        mem_wa_en;
	logic                        mem_wb_en;
	logic                        rd_issue;
	logic [srlm_pkg::ADDR_W-1:0] rd_addr;
	logic [srlm_pkg::ADDR_W-1:0] rd_addr_q;
	logic                        rd_valid;
	logic [srlm_pkg::DATA_W-1:0] mem_rd;
	logic [srlm_pkg::DATA_W-1:0] rd_value;

	assign mem_wa_en = cw & addr_present(cm_addr) & ~is_lock & ~is_scratch & ~is_fail; // [RULE14]
	assign mem_wb_en = hw_update.valid & addr_present(hw_update.addr); // [RULE20]
	assign rd_issue  = sample && ((next_count == srlm_pkg::LEN_ADDR) || (next_count == srlm_pkg::LEN_ONE)
		|| (next_count == srlm_pkg::LEN_TWO));
	assign rd_addr   = (next_count == srlm_pkg::LEN_ADDR) ? shift_in[srlm_pkg::ADDR_W-1:0]
		: (next_count == srlm_pkg::LEN_ONE) ? cmd_addr + srlm_pkg::ADDR_STEP : 7'(cmd_addr + 7'h02);

	srlm_regmem #(
		.AW (srlm_pkg::ADDR_W),
		.DW (srlm_pkg::DATA_W)
	) u_mem (
		.clock   (clock),
		.rst_b   (rst_b),
		.wa_en   (mem_wa_en),
		.wa_addr (cm_addr),
		.wa_data (cw_data),
		.wb_en   (mem_wb_en),
		.wb_addr (hw_update.addr),
		.wb_data (hw_update.data),
		.rd_addr (rd_addr),
		.rd_data (mem_rd)
	);

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_addr_q <= '0;
			rd_valid  <= 1'b0;
		end
		else
		begin
			rd_addr_q <= rd_addr;
			rd_valid  <= rd_issue;
		end
	end

	always_comb
	begin
		rd_value = mem_rd;
		if (!addr_present(rd_addr_q))
			rd_value = srlm_pkg::BYTE_ZERO; // [RULE14]
		else if (rd_addr_q == srlm_pkg::ADDR_LOCK)
			rd_value = fn_mode ? srlm_pkg::BYTE_ZERO : {1'b0, area_lock_bits}; // [RULE10] [RULE15]
		else if (in_area(srlm_pkg::LK_SCRATCH, rd_addr_q))
			rd_value = fn_mode ? srlm_pkg::BYTE_ZERO
				: scratch_memory[{2'(rd_addr_q - srlm_pkg::ADDR_SCRATCH_FIRST), 3'h0} +: srlm_pkg::DATA_W];
		else if (rd_addr_q == srlm_pkg::ADDR_IRQ_EN)
			rd_value[srlm_pkg::BIT_FAIL_IRQ_EN] = serial_failure_irq_enable & ~fn_mode; // [RULE10]
		else if (rd_addr_q == srlm_pkg::ADDR_FAIL_STATUS)
		begin
			rd_value = srlm_pkg::BYTE_ZERO;
			rd_value[srlm_pkg::BIT_FAIL_FLAG] = serial_failure_flag & ~fn_mode; // [RULE10]
		end
	end

	// ----------------------------------------
	// serial out, shifted on rising sck
	// ----------------------------------------
	logic [srlm_pkg::DATA_W-1:0] out_shift;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			out_shift    <= '0;
			spi_sdo      <= 1'b0;
			spi_sdo_oe_b <= 1'b1;
		end
		else
		begin
			spi_sdo_oe_b <= ~(frame_active & ~cs_b_s); // [RULE9]
			if (frame_start)
			begin
				out_shift <= '0;
				spi_sdo   <= 1'b0;
			end
			else if (rd_valid)
				out_shift <= rd_value;
			else if (sck_rise)
			begin
				spi_sdo   <= out_shift[srlm_pkg::DATA_W-1];
				out_shift <= {out_shift[srlm_pkg::DATA_W-2:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	scratch_hold_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE1]
		($past(area_lock_bits[srlm_pkg::LK_SCRATCH]) && $past(op_mode) != srlm_pkg::MODE_OFF) |-> $stable(scratch_memory))
		else $error("scratch changed while locked");

	generate
		for (genvar g = 0; g < srlm_pkg::LOCK_W; g++)
		begin : g_area
			area_block_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2] [RULE3] [RULE6]
				cw |-> !(area_lock_bits[g] && in_area(g, cm_addr)))
				else $error("commit into locked area");
		end
	endgenerate

	lock_fail_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE16]
		(write_end && len_ok && lock_hit && !clear_mode) |=> (serial_failure_flag && cm_state == srlm_pkg::CM_IDLE))
		else $error("locked write not rejected");

	len_fail_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE17]
		(write_end && !len_ok && !clear_mode) |=> (serial_failure_flag && !cw))
		else $error("bad length write not rejected");

	whole_commit_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE19]
		(commit_start && nbytes == 2'h3) |=> cw [*3] ##1 !cw)
		else $error("three byte commit not whole");

	fn_hide_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE10]
		(rd_valid && fn_mode && rd_addr_q == srlm_pkg::ADDR_LOCK && !frame_start) |=> out_shift == srlm_pkg::BYTE_ZERO)
		else $error("lock bits visible in forced normal");

	off_clear_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE11]
		op_mode == srlm_pkg::MODE_OFF |=> (area_lock_bits == srlm_pkg::LOCK_ZERO && !serial_failure_flag
			&& !serial_failure_irq_enable))
		else $error("off mode did not clear");

	bit7_zero_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE15]
		(rd_valid && rd_addr_q == srlm_pkg::ADDR_LOCK && !frame_start) |=> !out_shift[srlm_pkg::DATA_W-1])
		else $error("reserved lock bit read nonzero");

	quiet_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
		(!spi_enabled(op_mode) ##1 !spi_enabled(op_mode)) |=> spi_sdo_oe_b)
		else $error("sdo driven in disabled mode");

endmodule : srlm_lock_map

// [dv/srlm_host_model.sv]
module srlm_host_model (
	input  wire logic clock,
	input  wire logic spi_sdo_pin,
	output logic      spi_sck,
	output logic      spi_cs_b,
	output logic      spi_sdi
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// serial master
	// ----------------------------------------
	localparam int HALF = 8; // margin over the 4-clock minimum half period

	initial
	begin
		spi_sck  = 1'b0;
		spi_cs_b = 1'b1;
		spi_sdi  = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_clk

	// bits go out msb first, sampled by the device on falling sck
	task automatic xfer(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0000_0000;
		@(posedge clock);
		spi_cs_b <= 1'b0;
		wait_clk(HALF);
		for (int i = nbits - 1; i >= 0; i--)
		begin
			spi_sck <= 1'b1;
			spi_sdi <= tx[i];
			wait_clk(HALF);
			rx = {rx[30:0], spi_sdo_pin};
			spi_sck <= 1'b0;
			wait_clk(HALF);
		end
		spi_cs_b <= 1'b1;
		spi_sdi  <= ~tx[0]; // data line not held once deselected
		wait_clk(2 * HALF);
	endtask : xfer

endmodule : srlm_host_model

// [dv/test_spi_register_lock_and_map.sv]
module test_spi_register_lock_and_map;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic                 clock;
	logic                 rst_b;
	logic                 spi_sck;
	logic                 spi_cs_b;
	logic                 spi_sdi;
	logic                 spi_sdo;
	logic                 spi_sdo_oe_b;
	wire                  spi_sdo_pin;
	srlm_pkg::srlm_mode_t op_mode;
	srlm_pkg::srlm_wr_t   hw_update;
	srlm_pkg::srlm_wr_t   spi_commit;
	srlm_pkg::srlm_wr_t   last_commit;
	logic [6:0]           area_lock_bits;
	logic [31:0]          scratch_memory;
	logic [31:0]          rx;
	logic                 flag;
	logic                 irq_en;
	logic                 irq;
	int                   mismatches;
	int                   checks;
	int                   commits;
	int                   cycles;
	int                   n;

	assign spi_sdo_pin = spi_sdo_oe_b ? 1'bz : spi_sdo;

	srlm_lock_map u_dut (.clock(clock), .rst_b(rst_b), .spi_sck(spi_sck), .spi_cs_b(spi_cs_b),
		.spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_b(spi_sdo_oe_b), .op_mode(op_mode),
		.hw_update(hw_update), .spi_commit(spi_commit), .area_lock_bits(area_lock_bits),
		.scratch_memory(scratch_memory), .serial_failure_flag(flag),
		.serial_failure_irq_enable(irq_en), .serial_failure_irq(irq));

	srlm_host_model u_host (.clock(clock), .spi_sdo_pin(spi_sdo_pin), .spi_sck(spi_sck),
		.spi_cs_b(spi_cs_b), .spi_sdi(spi_sdi));

	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles++;
		if (spi_commit.valid === 1'b1)
		begin
			commits++;
			last_commit = spi_commit;
		end
		if (cycles == 40000) // far above the ~7.7k cycles the sequence needs
		begin
			mismatches++;
			$display("Error at %0t: timeout", $time);
			complete_run();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// data bytes packed from the top, first byte in d[23:16]
	task automatic wr(input int nbits, input logic [6:0] a, input logic [23:0] d);
		n = commits;
		u_host.xfer(nbits, {a, 1'b0, d} >> (32 - nbits), rx);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		u_host.xfer(16, {16'h0000, a, 1'b1, 8'h00}, rx);
		chk(rx[7:0], exp, "read data");
	endtask : rd

	task automatic post(input int k, input logic fl);
		chk(commits - n, k, "commit count");
		chk(flag, fl, "failure flag");
	endtask : post

	task automatic set_mode(input srlm_pkg::srlm_mode_t m);
		op_mode <= m;
		u_host.wait_clk(4);
	endtask : set_mode

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		rst_b = 1'b0;
		op_mode = srlm_pkg::MODE_NORMAL;
		hw_update = '0;
		mismatches = 0;
		checks = 0;
		commits = 0;
		cycles = 0;
		last_commit = '0;
		u_host.wait_clk(3);
		rst_b <= 1'b1;
		u_host.wait_clk(3);
		chk(area_lock_bits, 32'h0, "lock reset");
		wr(32, srlm_pkg::ADDR_SCRATCH_FIRST, 24'h112233);
		post(3, 1'b0);
		chk(scratch_memory[23:0], 32'h332211, "scratch");
		wr(16, srlm_pkg::ADDR_IRQ_EN, 24'h020000);
		chk(irq_en, 32'h1, "irq enable");
		wr(16, srlm_pkg::ADDR_LOCK, 24'h7F0000); // bit 7 kept zero
		chk(area_lock_bits, 32'h7F, "lock bits");
		rd(srlm_pkg::ADDR_LOCK, 8'h7F);
		for (int k = 0; k < srlm_pkg::LOCK_W; k++)
		begin
			wr(16, srlm_pkg::AREA_LAST[k], 24'hA50000);
			post(0, 1'b1);
			chk(irq, 32'h1, "irq");
			wr(16, srlm_pkg::ADDR_FAIL_STATUS, 24'h020000);
			post(1, 1'b0);
		end
		wr(24, 7'h05, 24'h010200);
		post(0, 1'b1);
		@(posedge clock);
		hw_update <= '{valid: 1'b1, addr: 7'h10, data: 8'hC3};
		@(posedge clock);
		hw_update <= '0;
		rd(7'h10, 8'hC3);
		set_mode(srlm_pkg::MODE_FORCED_NORMAL);
		rd(srlm_pkg::ADDR_LOCK, 8'h00);
		set_mode(srlm_pkg::MODE_FAILSAFE);
		chk({irq_en, flag}, 32'h0, "fail-safe clear");
		chk(area_lock_bits, 32'h7F, "locks kept");
		set_mode(srlm_pkg::MODE_SLEEP);
		wr(16, 7'h60, 24'h550000);
		post(0, 1'b0);
		set_mode(srlm_pkg::MODE_OFF);
		chk(area_lock_bits, 32'h0, "off clear");
		set_mode(srlm_pkg::MODE_STANDBY);
		wr(12, 7'h20, 24'h500000);
		post(0, 1'b1);
		wr(16, 7'h20, 24'h5A0000);
		post(1, 1'b1);
		chk({last_commit.addr, last_commit.data}, {7'h20, 8'h5A}, "commit");
		wr(16, 7'h0B, 24'hFF0000);
		post(0, 1'b1);
		rd(7'h0B, 8'h00);
		complete_run();
	end

endmodule : test_spi_register_lock_and_map
